//--- common/bccs_params.svh
`ifndef BCCS_PARAMS_SVH
`define BCCS_PARAMS_SVH

// ****************************************
// clock and debounce times
// ****************************************
`define BCCS_CLK_MHZ        50
`define BCCS_EN_FALL_US     2000
`define BCCS_EN_OFF_US      10
`define BCCS_COMP_US        100
`define BCCS_GATE_OK_US     15000
`define BCCS_STARTUP_US     1000

// ****************************************
// charge timer
// ****************************************
`define BCCS_TMR_W          22
`define BCCS_ABS_TIMEOUT    22'h1fffff
`define BCCS_PCHG_TIMEOUT   (`BCCS_ABS_TIMEOUT >> 3)

// ****************************************
// register map
// ****************************************
`define BCCS_ADDR_CTRL      8'h00
`define BCCS_ADDR_STATUS    8'h04
`define BCCS_ADDR_TIMER     8'h08
`define BCCS_CTRL_INHIBIT   0
`define BCCS_CTRL_RST       1'h0
`define BCCS_ST_FIRST       4
`define BCCS_ST_SECOND      5
`define BCCS_ST_GATE_UP     6
`define BCCS_ST_SWITCH      7
`define BCCS_ST_TDIS        8
`define BCCS_ST_COMP_PD     9

`endif

//--- common/bccs_pkg.sv
package bccs_pkg;

	// ****************************************
	// charger states
	// ****************************************
	typedef enum logic [3:0] {
		ST_OFF, ST_PWRCHK, ST_STARTUP, ST_PRECHG, ST_CC, ST_ABS, ST_FLOAT,
		ST_PRE_SUSP, ST_CC_SUSP, ST_ABS_SUSP, ST_FLT_SUSP, ST_SHUTDOWN, ST_FAULT
	} bccs_state_t;

	// ****************************************
	// comparator results
	// ****************************************
	typedef struct packed {
		logic vcc_ok;
		logic en_on;
		logic en_low;
		logic en_off;
		logic hdrm_ok;
		logic hdrm_low;
		logic rev;
		logic dd_low;
		logic dd_high;
		logic fb_cv;
		logic taper;
		logic temp_fault;
		logic gate_ok;
		logic hw_fault;
	} bccs_cmp_t;

endpackage

//--- logic/bccs_sync.sv
`timescale 1ns/100ps
`default_nettype none

module bccs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_reset,
	// levels
	input  wire logic [W-1:0] i_async,
	output var  logic [W-1:0] o_sync
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule // bccs_sync

`default_nettype wire

//--- logic/bccs_debounce.sv
`timescale 1ns/100ps
`default_nettype none

module bccs_debounce #(
	parameter int N = 2
) (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset,
	// level and its qualified copy
	input  wire logic i_level,
	output var  logic o_done
);

	localparam int W = $clog2(N + 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         done_nxt;

	// count saturates so a long level stays qualified
	always_comb begin
		cnt_nxt = '0;
		if (i_level) begin
			cnt_nxt = (cnt_r == W'(N)) ? cnt_r : cnt_r + W'(1);
		end
		done_nxt = (cnt_nxt == W'(N));
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			cnt_r  <= '0;
			o_done <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			o_done <= done_nxt;
		end
	end

endmodule // bccs_debounce

`default_nettype wire

//--- logic/bccs_ctrl.sv
`include "bccs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module bccs_ctrl #(
	parameter int STARTUP_CYC = `BCCS_STARTUP_US * `BCCS_CLK_MHZ,
	parameter int EN_FALL_CYC = `BCCS_EN_FALL_US * `BCCS_CLK_MHZ,
	parameter int COMP_CYC    = `BCCS_COMP_US * `BCCS_CLK_MHZ,
	parameter int GATE_OK_CYC = `BCCS_GATE_OK_US * `BCCS_CLK_MHZ
) (
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	// comparators, timer oscillator and strap
	input  wire bccs_pkg::bccs_cmp_t i_cmp,
	input  wire logic              i_tmr_tick,
	input  wire logic              i_timer_disable,
	// ahb-lite slave
	input  wire logic              i_hsel,
	input  wire logic [31:0]       i_haddr,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hwrite,
	input  wire logic [2:0]        i_hsize,
	input  wire logic [31:0]       i_hwdata,
	input  wire logic              i_hready,
	output var  logic              o_hreadyout,
	output var  logic              o_hresp,
	output var  logic [31:0]       o_hrdata,
	// open-drain status pins, enable pulls low
	output var  logic              o_status_out_first_oe,
	output var  logic              o_status_out_second_oe,
	// converter and input switch control
	output var  logic              o_switch_en,
	output var  logic              o_precharge_ref,
	output var  logic              o_float_select,
	output var  logic              o_comp_pulldown,
	output var  logic              o_input_switch_gate_up,
	output var  logic              o_input_switch_gate_down
);

	// ****************************************
	// comparator synchronisers
	// ****************************************
	localparam int CW = $bits(bccs_pkg::bccs_cmp_t);

	bccs_pkg::bccs_cmp_t c;
	logic [CW-1:0]       c_bits;

	bccs_sync #(.W(CW)) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_async   (i_cmp),
		.o_sync    (c_bits)
	);
	assign c = bccs_pkg::bccs_cmp_t'(c_bits);

	// ****************************************
	// debounce and delay counters
	// ****************************************
	bccs_pkg::bccs_state_t state_r;
	bccs_pkg::bccs_state_t state_nxt;
	logic                  gate_up_r;
	logic                  startup_done;
	logic                  en_fall_db;
	logic                  en_off_db;
	logic                  comp_done;
	logic                  gate_tmo;

	bccs_debounce #(.N(STARTUP_CYC)) u_startup (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_level   (state_r == bccs_pkg::ST_STARTUP),
		.o_done    (startup_done)
	);

	bccs_debounce #(.N(EN_FALL_CYC)) u_en_fall (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_level   (c.en_low),
		.o_done    (en_fall_db)
	);

	bccs_debounce #(.N(`BCCS_EN_OFF_US * `BCCS_CLK_MHZ)) u_en_off (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_level   (c.en_off),
		.o_done    (en_off_db)
	);

	bccs_debounce #(.N(COMP_CYC)) u_comp (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_level   (state_r == bccs_pkg::ST_SHUTDOWN),
		.o_done    (comp_done)
	);

	// clock keeps counting only while pull-up sources and gate is still low
	bccs_debounce #(.N(GATE_OK_CYC)) u_gate (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_level   (gate_up_r & ~c.gate_ok),
		.o_done    (gate_tmo)
	);

	// ****************************************
	// software control
	// ****************************************
	logic inhibit_r;
	logic tdis_r;
	logic tdis_nxt;
	logic shut_now;

	// strap is sampled while off, never under reset
	always_comb begin
		tdis_nxt = tdis_r;
		if (state_r == bccs_pkg::ST_OFF) begin
			tdis_nxt = i_timer_disable;
		end
	end

	assign shut_now = c.hdrm_low | c.rev | inhibit_r | en_fall_db | en_off_db;

	// ****************************************
	// charge state machine
	// ****************************************
	logic [`BCCS_TMR_W-1:0] tmr_r;
	logic [`BCCS_TMR_W-1:0] tmr_nxt;
	logic                   pchg_tmo;
	logic                   abs_tmo;
	logic                   active;

	assign pchg_tmo = ~tdis_r & (tmr_r > `BCCS_PCHG_TIMEOUT);
	assign abs_tmo  = ~tdis_r & (tmr_r > `BCCS_ABS_TIMEOUT);
	assign active   = (state_r != bccs_pkg::ST_OFF) && (state_r != bccs_pkg::ST_SHUTDOWN)
		&& (state_r != bccs_pkg::ST_FAULT);

	always_comb begin
		state_nxt = state_r;
		tmr_nxt   = tmr_r;
		unique case (state_r)
			bccs_pkg::ST_OFF: begin
				if (c.vcc_ok && c.en_on && !inhibit_r) begin
					state_nxt = bccs_pkg::ST_PWRCHK;
				end
			end
			bccs_pkg::ST_PWRCHK: begin
				state_nxt = c.hw_fault ? bccs_pkg::ST_FAULT : bccs_pkg::ST_STARTUP;
			end
			bccs_pkg::ST_STARTUP: begin
				if (startup_done) begin
					tmr_nxt   = '0;
					state_nxt = c.dd_low ? bccs_pkg::ST_PRECHG : bccs_pkg::ST_CC;
				end
			end
			bccs_pkg::ST_PRECHG: begin
				if (i_tmr_tick) begin
					tmr_nxt = tmr_r + `BCCS_TMR_W'(1);
				end
				if (c.temp_fault) begin
					tmr_nxt   = tmr_r;
					state_nxt = bccs_pkg::ST_PRE_SUSP;
				end else if (c.dd_high) begin
					tmr_nxt   = '0;
					state_nxt = bccs_pkg::ST_CC;
				end else if (pchg_tmo) begin
					state_nxt = bccs_pkg::ST_FAULT;
				end
			end
			bccs_pkg::ST_CC: begin
				if (c.temp_fault) begin
					state_nxt = bccs_pkg::ST_CC_SUSP;
				end else if (c.fb_cv) begin
					state_nxt = bccs_pkg::ST_ABS;
				end
			end
			bccs_pkg::ST_ABS: begin
				if (i_tmr_tick) begin
					tmr_nxt = tmr_r + `BCCS_TMR_W'(1);
				end
				if (c.temp_fault) begin
					tmr_nxt   = tmr_r;
					state_nxt = bccs_pkg::ST_ABS_SUSP;
				end else if (c.taper || abs_tmo) begin
					tmr_nxt   = '0;
					state_nxt = bccs_pkg::ST_FLOAT;
				end
			end
			bccs_pkg::ST_FLOAT: begin
				if (c.temp_fault) begin
					state_nxt = bccs_pkg::ST_FLT_SUSP;
				end
			end
			// suspends hold the timer and ignore the strap
			bccs_pkg::ST_PRE_SUSP: begin
				if (!c.temp_fault) state_nxt = bccs_pkg::ST_PRECHG;
			end
			bccs_pkg::ST_CC_SUSP: begin
				if (!c.temp_fault) state_nxt = bccs_pkg::ST_CC;
			end
			bccs_pkg::ST_ABS_SUSP: begin
				if (!c.temp_fault) state_nxt = bccs_pkg::ST_ABS;
			end
			bccs_pkg::ST_FLT_SUSP: begin
				if (!c.temp_fault) state_nxt = bccs_pkg::ST_FLOAT;
			end
			bccs_pkg::ST_SHUTDOWN: begin
				if (comp_done) begin
					tmr_nxt   = '0;
					state_nxt = bccs_pkg::ST_OFF;
				end
			end
			bccs_pkg::ST_FAULT: begin
				state_nxt = bccs_pkg::ST_FAULT;
			end
			default: begin
				state_nxt = bccs_pkg::ST_FAULT;
			end
		endcase
		// shutdown outranks every charge decision
		if (active && shut_now) begin
			state_nxt = bccs_pkg::ST_SHUTDOWN;
		end else if (active && gate_tmo) begin
			state_nxt = bccs_pkg::ST_FAULT;
		end
	end

	// ****************************************
	// output decode
	// ****************************************
	function automatic logic is_charging(input bccs_pkg::bccs_state_t s);
		is_charging = (s == bccs_pkg::ST_PRECHG) || (s == bccs_pkg::ST_CC)
			|| (s == bccs_pkg::ST_ABS);
	endfunction

	function automatic logic is_flagged(input bccs_pkg::bccs_state_t s);
		is_flagged = (s == bccs_pkg::ST_FAULT) || (s == bccs_pkg::ST_PRE_SUSP)
			|| (s == bccs_pkg::ST_CC_SUSP) || (s == bccs_pkg::ST_ABS_SUSP)
			|| (s == bccs_pkg::ST_FLT_SUSP);
	endfunction

	logic first_nxt;
	logic second_nxt;
	logic switch_nxt;
	logic gate_up_nxt;
	logic comp_nxt;

	always_comb begin
		// pair (second, first): 11 off, 10 charging, 00 float, 01 fault or suspend
		first_nxt  = is_charging(state_nxt) || (state_nxt == bccs_pkg::ST_FLOAT);
		second_nxt = is_flagged(state_nxt) || (state_nxt == bccs_pkg::ST_FLOAT);
		switch_nxt = is_charging(state_nxt) || (state_nxt == bccs_pkg::ST_FLOAT);
		// reverse supply drops the registered pull-up on the clock edge after the synchronised level is seen
		gate_up_nxt = (state_nxt != bccs_pkg::ST_OFF) && (state_nxt != bccs_pkg::ST_SHUTDOWN)
			&& (state_nxt != bccs_pkg::ST_FAULT) && c.hdrm_ok && !c.rev;
		comp_nxt = (state_nxt == bccs_pkg::ST_OFF) || (state_nxt == bccs_pkg::ST_FAULT)
			|| ((state_nxt == bccs_pkg::ST_SHUTDOWN) && comp_done);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_r                  <= bccs_pkg::ST_OFF;
			tmr_r                    <= '0;
			tdis_r                   <= 1'b0;
			gate_up_r                <= 1'b0;
			o_status_out_first_oe    <= 1'b0;
			o_status_out_second_oe   <= 1'b0;
			o_switch_en              <= 1'b0;
			o_precharge_ref          <= 1'b0;
			o_float_select           <= 1'b0;
			o_comp_pulldown          <= 1'b1;
			o_input_switch_gate_up   <= 1'b0;
			o_input_switch_gate_down <= 1'b1;
		end else begin
			state_r                  <= state_nxt;
			tmr_r                    <= tmr_nxt;
			tdis_r                   <= tdis_nxt;
			gate_up_r                <= gate_up_nxt;
			o_status_out_first_oe    <= first_nxt;
			o_status_out_second_oe   <= second_nxt;
			o_switch_en              <= switch_nxt;
			o_precharge_ref          <= (state_nxt == bccs_pkg::ST_PRECHG);
			o_float_select           <= (state_nxt == bccs_pkg::ST_FLOAT);
			o_comp_pulldown          <= comp_nxt;
			o_input_switch_gate_up   <= gate_up_nxt;
			o_input_switch_gate_down <= !gate_up_nxt;
		end
	end

	// ****************************************
	// ahb-lite register slave
	// ****************************************
	logic        aphase;
	logic        wr_pend_r;
	logic        wr_pend_nxt;
	logic [7:0]  wr_addr_r;
	logic [7:0]  wr_addr_nxt;
	logic        inhibit_nxt;
	logic [31:0] rdata_nxt;

	function automatic logic [31:0] rd_mux(input logic [31:0] a);
		rd_mux = 32'h0000_0000;
		if (a[31:8] == 24'h00_0000) begin
			unique case (a[7:0])
				`BCCS_ADDR_CTRL:   rd_mux[`BCCS_CTRL_INHIBIT] = inhibit_r;
				`BCCS_ADDR_STATUS: begin
					rd_mux[3:0]             = state_r;
					rd_mux[`BCCS_ST_FIRST]   = o_status_out_first_oe;
					rd_mux[`BCCS_ST_SECOND]  = o_status_out_second_oe;
					rd_mux[`BCCS_ST_GATE_UP] = o_input_switch_gate_up;
					rd_mux[`BCCS_ST_SWITCH]  = o_switch_en;
					rd_mux[`BCCS_ST_TDIS]    = tdis_r;
					rd_mux[`BCCS_ST_COMP_PD] = o_comp_pulldown;
				end
				`BCCS_ADDR_TIMER:  rd_mux[`BCCS_TMR_W-1:0] = tmr_r;
				default:           rd_mux = 32'h0000_0000;
			endcase
		end
	endfunction

	// slave never stalls, so every transfer finishes in one data cycle
	assign aphase = i_hsel && i_htrans[1] && i_hready;

	always_comb begin
		wr_pend_nxt = aphase && i_hwrite;
		wr_addr_nxt = (aphase && i_hwrite && (i_haddr[31:8] == 24'h00_0000)) ? i_haddr[7:0]
			: 8'hff;
		inhibit_nxt = inhibit_r;
		if (wr_pend_r && (wr_addr_r == `BCCS_ADDR_CTRL)) begin
			inhibit_nxt = i_hwdata[`BCCS_CTRL_INHIBIT];
		end
		rdata_nxt = (aphase && !i_hwrite) ? rd_mux(i_haddr) : 32'h0000_0000;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 8'hff;
			inhibit_r   <= `BCCS_CTRL_RST;
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend_r   <= wr_pend_nxt;
			wr_addr_r   <= wr_addr_nxt;
			inhibit_r   <= inhibit_nxt;
			o_hrdata    <= rdata_nxt;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end

endmodule // bccs_ctrl

`default_nettype wire

//--- verif/bccs_analog_model.sv
`timescale 1ns/100ps
`default_nettype none

module bccs_analog_model (
	// clock
	input  wire logic       i_ref_clk,
	// gate drive, charge time in cycles, ff never charges
	input  wire logic       i_gate_up,
	input  wire logic       i_gate_down,
	input  wire logic [7:0] i_gate_dly,
	output var  logic       o_gate_ok,
	// open-drain status pins with pull-ups
	input  wire logic       i_first_oe,
	input  wire logic       i_second_oe,
	output var  logic       o_pin_first,
	output var  logic       o_pin_second
);
	logic [7:0] charge_r = 8'h00;

	// a pull-down empties the gate on the next clock, so ok outlives the drive by one cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_gate_down || !i_gate_up) begin
			charge_r <= 8'h00;
		end else if (charge_r != 8'hff) begin
			charge_r <= charge_r + 8'h01;
		end
	end
	assign o_gate_ok = (i_gate_dly != 8'hff) && (charge_r >= i_gate_dly);
	assign o_pin_first = i_first_oe ? 1'b0 : 1'b1;
	assign o_pin_second = i_second_oe ? 1'b0 : 1'b1;
endmodule // bccs_analog_model

`default_nettype wire

//--- verif/bccs_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module bccs_ctrl_asserts #(
	parameter int EN_FALL_CYC = 100000,
	parameter int GATE_OK_CYC = 750000
) (
	// clock and reset
	input  wire logic                i_ref_clk,
	input  wire logic                i_reset,
	// watched ports
	input  wire bccs_pkg::bccs_cmp_t i_cmp,
	input  wire logic                o_status_out_first_oe,
	input  wire logic                o_status_out_second_oe,
	input  wire logic                o_switch_en,
	input  wire logic                o_precharge_ref,
	input  wire logic                o_float_select,
	input  wire logic                o_input_switch_gate_up,
	input  wire logic                o_input_switch_gate_down
);
	int en_cnt;
	int gate_cnt;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	// ****************************************
	// run lengths, raw inputs so sync lag gives slack
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			en_cnt <= 0;
			gate_cnt <= 0;
		end else begin
			en_cnt <= i_cmp.en_low ? en_cnt + 1 : 0;
			gate_cnt <= (o_input_switch_gate_up && !i_cmp.gate_ok) ? gate_cnt + 1 : 0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_float_pair_target: assert property (
		o_status_out_first_oe && o_status_out_second_oe |-> o_float_select)
		else $error("float status without float target");
	a_switch_first_low: assert property (o_switch_en |-> o_status_out_first_oe)
		else $error("switching with first status released");
	a_prechg_ref_charging: assert property (
		o_precharge_ref && o_switch_en |-> o_status_out_first_oe && !o_status_out_second_oe)
		else $error("precharge reference outside charging");
	a_start_pair_charging: assert property (
		$rose(o_switch_en) && !$past(o_status_out_second_oe)
		|-> o_status_out_first_oe && !o_status_out_second_oe)
		else $error("switching began without charging status");
	a_rev_gate_down: assert property (i_cmp.rev [*3] |-> ##2 !o_input_switch_gate_up)
		else $error("gate still up under reverse supply");
	a_hdrm_shut_now: assert property (
		i_cmp.hdrm_low [*3] |-> ##2 !o_switch_en && o_input_switch_gate_down)
		else $error("no immediate shutdown on headroom lockout");
	a_temp_stops_switch: assert property (i_cmp.temp_fault [*3] |-> ##2 !o_switch_en)
		else $error("switching during temperature fault");
	a_en_low_debounce: assert property (en_cnt > EN_FALL_CYC + 4 |-> !o_switch_en)
		else $error("enable low not shut down after debounce");
	a_gate_ok_limit: assert property (
		gate_cnt > GATE_OK_CYC + 4 |-> !o_input_switch_gate_up)
		else $error("gate not ok past limit without fault");
endmodule // bccs_ctrl_asserts

bind bccs_ctrl bccs_ctrl_asserts #(
	.EN_FALL_CYC(EN_FALL_CYC),
	.GATE_OK_CYC(GATE_OK_CYC)
) u_asserts (
	.i_ref_clk(i_ref_clk),
	.i_reset(i_reset),
	.i_cmp(i_cmp),
	.o_status_out_first_oe(o_status_out_first_oe),
	.o_status_out_second_oe(o_status_out_second_oe),
	.o_switch_en(o_switch_en),
	.o_precharge_ref(o_precharge_ref),
	.o_float_select(o_float_select),
	.o_input_switch_gate_up(o_input_switch_gate_up),
	.o_input_switch_gate_down(o_input_switch_gate_down)
);

`default_nettype wire

//--- verif/tb_battery_charge_state_controller.sv
`timescale 1ns/100ps
`default_nettype none

module tb_battery_charge_state_controller;
	logic                i_ref_clk = 1'b0;
	logic                i_reset = 1'b1;
	bccs_pkg::bccs_cmp_t cmp = '0;
	bccs_pkg::bccs_cmp_t cmp_in;
	logic                tick = 1'b0;
	logic                tdis = 1'b0;
	logic                hsel = 1'b0;
	logic [31:0]         haddr = 32'h0;
	logic [1:0]          htrans = 2'h0;
	logic                hwrite = 1'b0;
	logic [31:0]         hwdata = 32'h0;
	logic [7:0]          gdly = 8'h1e;
	logic [31:0]         hrdata;
	logic [31:0]         rd;
	logic                hready, hresp, f_oe, s_oe, sw, pref, fsel, comp, gup, gdn;
	logic                gate_ok, pin_f, pin_s;
	int                  errors = 0;
	int                  num_checks = 0;

	always_comb begin
		cmp_in = cmp;
		cmp_in.gate_ok = gate_ok;
	end

	bccs_ctrl #(.STARTUP_CYC(20), .EN_FALL_CYC(40), .COMP_CYC(10), .GATE_OK_CYC(60)) uut (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cmp(cmp_in), .i_tmr_tick(tick),
		.i_timer_disable(tdis), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.o_status_out_first_oe(f_oe), .o_status_out_second_oe(s_oe), .o_switch_en(sw),
		.o_precharge_ref(pref), .o_float_select(fsel), .o_comp_pulldown(comp),
		.o_input_switch_gate_up(gup), .o_input_switch_gate_down(gdn));

	bccs_analog_model u_far (.i_ref_clk(i_ref_clk), .i_gate_up(gup), .i_gate_down(gdn),
		.i_gate_dly(gdly), .o_gate_ok(gate_ok), .i_first_oe(f_oe), .i_second_oe(s_oe),
		.o_pin_first(pin_f), .o_pin_second(pin_s));

	initial begin
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge i_ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge i_ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_ref_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wait_st(input logic [3:0] s);
		int n;
		n = 0;
		do begin
			bus(1'b0, 32'h4, 32'h0);
			n++;
		end while (rd[3:0] !== s && n < 400);
		chk({28'h0, rd[3:0]}, {28'h0, s});
	endtask
	task automatic tick_n(input int n);
		repeat (n) begin
			@(posedge i_ref_clk);
			tick <= 1'b1;
			@(posedge i_ref_clk);
			tick <= 1'b0;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_powerup();
		@(posedge i_ref_clk);
		cmp.vcc_ok <= 1'b1;
		cmp.en_on <= 1'b1;
		cmp.hdrm_ok <= 1'b1;
		cmp.dd_low <= 1'b1;
		cyc(4);
		chk({31'h0, pin_s}, 32'h1);
		wait_st(4'h3);
		chk({28'h0, sw, pref, pin_s, pin_f}, 32'he);
		$display("power-up test done");
	endtask
	task automatic t_charge();
		tick_n(3);
		rd_chk(32'h8, 32'h3);
		@(posedge i_ref_clk);
		cmp.dd_low <= 1'b0;
		cmp.dd_high <= 1'b1;
		wait_st(4'h4);
		tick_n(2);
		rd_chk(32'h8, 32'h0);
		@(posedge i_ref_clk);
		cmp.fb_cv <= 1'b1;
		wait_st(4'h5);
		tick_n(2);
		@(posedge i_ref_clk);
		cmp.temp_fault <= 1'b1;
		wait_st(4'h9);
		tick_n(2);
		rd_chk(32'h8, 32'h2);
		@(posedge i_ref_clk);
		cmp.temp_fault <= 1'b0;
		wait_st(4'h5);
		tick_n(1);
		rd_chk(32'h8, 32'h3);
		@(posedge i_ref_clk);
		cmp.taper <= 1'b1;
		wait_st(4'h6);
		rd_chk(32'h8, 32'h0);
		chk({29'h0, fsel, pin_s, pin_f}, 32'h4);
		@(posedge i_ref_clk);
		cmp.temp_fault <= 1'b1;
		wait_st(4'ha);
		chk({29'h0, sw, pin_s, pin_f}, 32'h1);
		@(posedge i_ref_clk);
		cmp.temp_fault <= 1'b0;
		cmp.fb_cv <= 1'b0;
		cmp.taper <= 1'b0;
		wait_st(4'h6);
		$display("charge cycle test done");
	endtask
	task automatic t_inhibit();
		bus(1'b1, 32'h0, 32'h1);
		cyc(4);
		chk({29'h0, sw, gdn, comp}, 32'h2);
		wait_st(4'h0);
		chk({31'h0, comp}, 32'h1);
		rd_chk(32'h0, 32'h1);
		rd_chk(32'h40, 32'h0);
		bus(1'b1, 32'h0, 32'h0);
		wait_st(4'h4);
		$display("inhibit test done");
	endtask
	task automatic t_en_low();
		@(posedge i_ref_clk);
		cmp.en_on <= 1'b0;
		cmp.en_low <= 1'b1;
		cyc(35);
		chk({31'h0, sw}, 32'h1);
		cyc(15);
		chk({31'h0, sw}, 32'h0);
		@(posedge i_ref_clk);
		cmp.en_low <= 1'b0;
		cmp.en_on <= 1'b1;
		wait_st(4'h4);
		$display("enable debounce test done");
	endtask
	task automatic t_rev();
		@(posedge i_ref_clk);
		gdly <= 8'h04;
		cmp.rev <= 1'b1;
		cyc(5);
		chk({30'h0, gup, gdn}, 32'h1);
		@(posedge i_ref_clk);
		cmp.rev <= 1'b0;
		wait_st(4'h4);
		$display("reverse supply test done");
	endtask
	task automatic t_fault();
		@(posedge i_ref_clk);
		gdly <= 8'hff;
		cmp.hdrm_low <= 1'b1;
		cmp.hdrm_ok <= 1'b0;
		wait_st(4'hb);
		@(posedge i_ref_clk);
		cmp.hdrm_low <= 1'b0;
		cmp.hdrm_ok <= 1'b1;
		wait_st(4'hc);
		chk({30'h0, pin_s, pin_f}, 32'h1);
		cyc(100);
		wait_st(4'hc);
		@(posedge i_ref_clk);
		i_reset <= 1'b1;
		cmp.vcc_ok <= 1'b0;
		cyc(3);
		@(posedge i_ref_clk);
		i_reset <= 1'b0;
		wait_st(4'h0);
		$display("latched fault test done");
	endtask
	task automatic t_strap();
		@(posedge i_ref_clk);
		tdis <= 1'b1;
		gdly <= 8'h1e;
		cmp.vcc_ok <= 1'b1;
		cmp.dd_high <= 1'b0;
		cmp.dd_low <= 1'b1;
		wait_st(4'h3);
		chk({31'h0, rd[8]}, 32'h1);
		@(posedge i_ref_clk);
		cmp.dd_low <= 1'b0;
		cmp.dd_high <= 1'b1;
		cmp.temp_fault <= 1'b1;
		wait_st(4'h7);
		@(posedge i_ref_clk);
		cmp.temp_fault <= 1'b0;
		wait_st(4'h4);
		@(posedge i_ref_clk);
		cmp.fb_cv <= 1'b1;
		cmp.taper <= 1'b1;
		wait_st(4'h6);
		@(posedge i_ref_clk);
		cmp.en_on <= 1'b0;
		cmp.en_off <= 1'b1;
		cyc(450);
		chk({31'h0, sw}, 32'h1);
		cyc(60);
		chk({30'h0, sw, gdn}, 32'h1);
		@(posedge i_ref_clk);
		cmp.en_off <= 1'b0;
		cmp.en_on <= 1'b1;
		cmp.hw_fault <= 1'b1;
		wait_st(4'hc);
		$display("timer strap test done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		cyc(16);
		@(posedge i_ref_clk);
		i_reset <= 1'b0;
		t_powerup();
		t_charge();
		t_inhibit();
		t_en_low();
		t_rev();
		t_fault();
		t_strap();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge i_ref_clk);
		errors++;
		close_out();
	end
endmodule // tb_battery_charge_state_controller

`default_nettype wire
